//--- rtl/hbfs_params.svh
// Constants for the half-bridge fault supervisor: offsets, field positions, resets, timing.
`ifndef HBFS_PARAMS_SVH
`define HBFS_PARAMS_SVH

// System clock rate in MHz (period 40 ns).
`define HBFS_CLK_MHZ 25

// Register byte offsets on the APB bus.
`define HBFS_ADDR_GLOBAL 12'h000
`define HBFS_ADDR_OC_A 12'h004
`define HBFS_ADDR_OC_B 12'h008
`define HBFS_ADDR_OL_A 12'h00C
`define HBFS_ADDR_OL_B 12'h010
`define HBFS_ADDR_ACT 12'h014
`define HBFS_ADDR_LIVE 12'h018

// Field positions in the global status register.
`define HBFS_BIT_PREWARN 1
`define HBFS_BIT_TSD 2
`define HBFS_BIT_OV 4
`define HBFS_BIT_UV 5
`define HBFS_BIT_LOAD_ERR 6

// Field positions in the activation control register.
`define HBFS_ACT_HS_LSB 0
`define HBFS_ACT_LS_LSB 8

// Reset values.
`define HBFS_RST_ACT 32'h0000_0000
`define HBFS_RST_STATUS 6'h00

// Filter times in nanoseconds, and their least cycle counts (rounded up).
`define HBFS_OC_FILTER_NS 10000
`define HBFS_OL_FILTER_NS 200000
`define HBFS_OC_FILTER_CYC ((`HBFS_OC_FILTER_NS * `HBFS_CLK_MHZ + 999) / 1000)
`define HBFS_OL_FILTER_CYC ((`HBFS_OL_FILTER_NS * `HBFS_CLK_MHZ + 999) / 1000)

`endif

//--- rtl/hbfs_pkg.sv
// Types shared by the half-bridge fault supervisor design files.
package hbfs_pkg;
  // One bit per half-bridge (six of them).
  typedef logic [5:0] hbfs_bridge_t;
  // Width of the fault filter counters.
  typedef logic [15:0] hbfs_count_t;
endpackage

//--- rtl/hbfs_filter.sv
// Fault filter: a counter that reports when a condition has held for a set number of cycles.
`timescale 1ns/1ns
module hbfs_filter
  import hbfs_pkg::*;
#(
  parameter hbfs_count_t TERMINAL = 16'h00FA
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cond_in,
  output logic expired_out
);

  hbfs_count_t count_reg; // Cycles for which the condition has held so far.
  hbfs_count_t count_next; // Next counter value.
  logic expired_reg; // High once the condition has held for the full count.
  logic expired_next; // Next expired value.

  // The count restarts whenever the condition drops, so short glitches never accumulate.
  always_comb begin
    count_next = count_reg;
    expired_next = 1'b0;
    if (!cond_in) begin
      count_next = '0;
    end else if (count_reg < TERMINAL) begin
      count_next = count_reg + 16'h0001;
    end else begin
      expired_next = 1'b1;
    end
  end

  // Register the counter and the expired level.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired_out = expired_reg;

endmodule // hbfs_filter

//--- rtl/hbfs_top.sv
// Half-bridge fault supervisor: latched diagnostics, output shutdown and an APB register file.
//
// Overview of operation
// R1 - Overcurrent or open load sets load error
// R2 - Overcurrent latches per-switch overcurrent bit
// R3 - Open load latches per-switch bit, output unchanged
// R4 - Temperature warning latches prewarning flag only
// R5 - Thermal shutdown latches flag, outputs off
// R6 - Undervoltage latches flag, outputs auto-recover
// R7 - Overvoltage latches flag, outputs auto-recover
// R8 - Faults never alter stored activation bits
// R9 - Overcurrent filter expiry latches switch off
// R10 - Switch stays off while overcurrent bit set
// R11 - Host clears error bit to reactivate
// R12 - Open load takes no protective action
// R13 - Prewarning stays latched, outputs stay active
// R14 - Open load blanked during active free-wheeling
// R15 - Comparators synchronised; counter filter, parameter count
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "hbfs_params.svh"
module hbfs_top
  import hbfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave port.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Asynchronous comparator levels from the power stages and monitors.
  input wire logic [5:0] hs_oc_cmp_in,
  input wire logic [5:0] ls_oc_cmp_in,
  input wire logic [5:0] hs_ol_cmp_in,
  input wire logic [5:0] ls_ol_cmp_in,
  input wire logic temp_warn_cmp_in,
  input wire logic temp_sd_cmp_in,
  input wire logic supply_uv_cmp_in,
  input wire logic supply_ov_cmp_in,
  // Free-wheeling indication from the PWM engine, same clock.
  input wire logic [5:0] hs_fw_active_in,
  input wire logic [5:0] ls_fw_active_in,
  // Gate commands to the output stages; low means the switch is off.
  output logic [5:0] hs_drive_out,
  output logic [5:0] ls_drive_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers.

  localparam int NSYNC = 28; // Width of the bundle of comparator inputs.
  logic [NSYNC-1:0] cmp_raw; // Raw asynchronous comparator levels.
  logic [NSYNC-1:0] sync1_reg; // First stage; read only by the second stage.
  logic [NSYNC-1:0] sync2_reg; // Second stage; the only copy logic reads.
  logic [NSYNC-1:0] sync1_next; // Next first-stage value.
  logic [NSYNC-1:0] sync2_next; // Next second-stage value.

  assign cmp_raw = {supply_ov_cmp_in, supply_uv_cmp_in, temp_sd_cmp_in, temp_warn_cmp_in,
                    ls_ol_cmp_in, hs_ol_cmp_in, ls_oc_cmp_in, hs_oc_cmp_in};

  // Two flops keep metastability out of the fault logic.
  always_comb begin
    sync1_next = cmp_raw; // [R15]
    sync2_next = sync1_reg; // [R15]
  end

  // Register the synchroniser stages.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic [11:0] oc_level; // Synchronised overcurrent levels, high sides in the low half.
  logic [11:0] ol_level; // Synchronised open-load levels, same order.
  logic warn_level; // Synchronised temperature warning.
  logic sd_level; // Synchronised thermal shutdown.
  logic uv_level; // Synchronised supply undervoltage.
  logic ov_level; // Synchronised supply overvoltage.

  assign oc_level = sync2_reg[11:0];
  assign ol_level = sync2_reg[23:12];
  assign warn_level = sync2_reg[24];
  assign sd_level = sync2_reg[25];
  assign uv_level = sync2_reg[26];
  assign ov_level = sync2_reg[27];

  //////////////////////////////////////////////////////////////////////////////
  // Per-switch fault filters.

  logic [11:0] enable_vec; // Stored activation bits, high sides in the low half.
  logic [11:0] drive_vec; // Switches actually driven on this cycle.
  logic [11:0] fw_vec; // Switches serving as active free-wheeling.
  logic [11:0] oc_expired; // Overcurrent persisted for the full filter time.
  logic [11:0] ol_expired; // Open load persisted for the full filter time.

  assign fw_vec = {ls_fw_active_in, hs_fw_active_in};

  // Filters run only on a driven switch, as detection is meaningful only while it conducts.
  for (genvar i = 0; i < 12; i++) begin : g_filter
    hbfs_filter #(
      .TERMINAL(16'(`HBFS_OC_FILTER_CYC))
    ) u_oc_filter (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .cond_in(oc_level[i] & drive_vec[i]), // [R9] [R15]
      .expired_out(oc_expired[i])
    );
    hbfs_filter #(
      .TERMINAL(16'(`HBFS_OL_FILTER_CYC))
    ) u_ol_filter (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .cond_in(ol_level[i] & drive_vec[i] & ~fw_vec[i]), // [R14]
      .expired_out(ol_expired[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic wr_en; // A write completes this cycle.
  logic setup_rd; // Setup phase of a read; read data is captured now.
  logic addr_ok; // The address names a register.
  logic [31:0] wmask; // Write data used as a write-one-to-clear mask.

  assign wr_en = psel_in & penable_in & pwrite_in & addr_ok;
  assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
  assign wmask = pwdata_in;

  // Decode the mapped word addresses.
  always_comb begin
    case (paddr_in)
      `HBFS_ADDR_GLOBAL, `HBFS_ADDR_OC_A, `HBFS_ADDR_OC_B, `HBFS_ADDR_OL_A,
      `HBFS_ADDR_OL_B, `HBFS_ADDR_ACT, `HBFS_ADDR_LIVE: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Zero wait states; an unmapped address is answered with an error in the access phase.
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Status flags and activation control.

  logic [11:0] oc_reg; // Latched overcurrent bits.
  logic [11:0] oc_next; // Next overcurrent bits.
  logic [11:0] ol_reg; // Latched open-load bits.
  logic [11:0] ol_next; // Next open-load bits.
  logic prewarn_reg; // Thermal prewarning flag.
  logic prewarn_next; // Next prewarning flag.
  logic tsd_reg; // Thermal shutdown flag.
  logic tsd_next; // Next thermal shutdown flag.
  logic uv_reg; // Supply undervoltage flag.
  logic uv_next; // Next undervoltage flag.
  logic ov_reg; // Supply overvoltage flag.
  logic ov_next; // Next overvoltage flag.
  logic lerr_reg; // Global load error flag.
  logic lerr_next; // Next load error flag.
  logic [11:0] act_reg; // Stored half-bridge activation bits.
  logic [11:0] act_next; // Next activation bits.
  logic [11:0] clr_oc; // Host clear mask for overcurrent bits.
  logic [11:0] clr_ol; // Host clear mask for open-load bits.
  logic [31:0] clr_glb; // Host clear mask for global flags.

  assign enable_vec = act_reg;

  // Clear masks: each status register is write-one-to-clear.
  always_comb begin
    clr_oc = '0;
    clr_ol = '0;
    clr_glb = '0;
    if (wr_en) begin
      case (paddr_in)
        `HBFS_ADDR_GLOBAL: clr_glb = wmask; // [R11]
        `HBFS_ADDR_OC_A: clr_oc[5:0] = wmask[5:0]; // [R11]
        `HBFS_ADDR_OC_B: clr_oc[11:6] = wmask[5:0]; // [R11]
        `HBFS_ADDR_OL_A: clr_ol[5:0] = wmask[5:0];
        `HBFS_ADDR_OL_B: clr_ol[11:6] = wmask[5:0];
        default: begin
          clr_oc = '0;
        end
      endcase
    end
  end

  // Next flag values. A set in the cycle of a clear always wins, so no event is lost.
  always_comb begin
    oc_next = (oc_reg & ~clr_oc) | oc_expired; // [R2] [R9] [R10]
    ol_next = (ol_reg & ~clr_ol) | ol_expired; // [R3] [R12]
    prewarn_next = (prewarn_reg & ~clr_glb[`HBFS_BIT_PREWARN]) | warn_level; // [R4] [R13]
    tsd_next = (tsd_reg & ~clr_glb[`HBFS_BIT_TSD]) | sd_level; // [R5]
    uv_next = (uv_reg & ~clr_glb[`HBFS_BIT_UV]) | uv_level; // [R6]
    ov_next = (ov_reg & ~clr_glb[`HBFS_BIT_OV]) | ov_level; // [R7]
    lerr_next = (lerr_reg & ~clr_glb[`HBFS_BIT_LOAD_ERR])
                | (|oc_expired) | (|ol_expired); // [R1]
    act_next = act_reg;
    // Only the host changes the activation bits; faults leave them untouched.
    if (wr_en && (paddr_in == `HBFS_ADDR_ACT)) begin
      act_next[5:0] = pwdata_in[`HBFS_ACT_HS_LSB +: 6]; // [R8]
      act_next[11:6] = pwdata_in[`HBFS_ACT_LS_LSB +: 6]; // [R8]
    end
  end

  // Register the flags and the activation bits.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_reg <= '0;
      ol_reg <= '0;
      prewarn_reg <= 1'b0;
      tsd_reg <= 1'b0;
      uv_reg <= 1'b0;
      ov_reg <= 1'b0;
      lerr_reg <= 1'b0;
      act_reg <= 12'h000;
    end else begin
      oc_reg <= oc_next;
      ol_reg <= ol_next;
      prewarn_reg <= prewarn_next;
      tsd_reg <= tsd_next;
      uv_reg <= uv_next;
      ov_reg <= ov_next;
      lerr_reg <= lerr_next;
      act_reg <= act_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage gating.

  logic [11:0] drive_reg; // Registered gate commands.
  logic [11:0] drive_next; // Next gate commands.
  logic global_off; // Any condition that turns every stage off.

  // Thermal shutdown holds off through its latched flag; the supply faults follow the live
  // level, so stages return by themselves once the supply is back in range.
  assign global_off = tsd_reg | uv_level | ov_level; // [R5] [R6] [R7]

  // A switch drives only while enabled, free of a latched overcurrent and of global faults.
  // Open-load and prewarning flags deliberately play no part here.
  always_comb begin
    drive_next = enable_vec & ~oc_reg & ~oc_expired & {12{~global_off}}; // [R8] [R10] [R12] [R13]
  end

  // Register the gate commands.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_reg <= 12'h000;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive_vec = drive_reg;
  assign hs_drive_out = drive_reg[5:0];
  assign ls_drive_out = drive_reg[11:6];

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [31:0] rdata_reg; // Read data captured in the setup phase.
  logic [31:0] rdata_next; // Next read data.
  logic [31:0] rd_mux; // Read view of the addressed register.

  // Select the addressed register; unused bits read as zero.
  always_comb begin
    rd_mux = '0;
    case (paddr_in)
      `HBFS_ADDR_GLOBAL: begin
        rd_mux[`HBFS_BIT_PREWARN] = prewarn_reg;
        rd_mux[`HBFS_BIT_TSD] = tsd_reg;
        rd_mux[`HBFS_BIT_OV] = ov_reg;
        rd_mux[`HBFS_BIT_UV] = uv_reg;
        rd_mux[`HBFS_BIT_LOAD_ERR] = lerr_reg;
      end
      `HBFS_ADDR_OC_A: rd_mux[5:0] = oc_reg[5:0];
      `HBFS_ADDR_OC_B: rd_mux[5:0] = oc_reg[11:6];
      `HBFS_ADDR_OL_A: rd_mux[5:0] = ol_reg[5:0];
      `HBFS_ADDR_OL_B: rd_mux[5:0] = ol_reg[11:6];
      `HBFS_ADDR_ACT: begin
        rd_mux[`HBFS_ACT_HS_LSB +: 6] = act_reg[5:0];
        rd_mux[`HBFS_ACT_LS_LSB +: 6] = act_reg[11:6];
      end
      `HBFS_ADDR_LIVE: begin
        rd_mux[`HBFS_ACT_HS_LSB +: 6] = drive_reg[5:0];
        rd_mux[`HBFS_ACT_LS_LSB +: 6] = drive_reg[11:6];
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Capture during setup so the data come straight from a flop in the access phase.
  always_comb begin
    rdata_next = rdata_reg;
    if (setup_rd) begin
      rdata_next = rd_mux;
    end
  end

  // Register the read data.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata_out = rdata_reg;

endmodule // hbfs_top

//--- sim/hbfs_checker_asserts.sv
// Port-level concurrent checks for the half-bridge fault supervisor.
`timescale 1ns/1ns
`include "hbfs_params.svh"
module hbfs_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [5:0] hs_oc_cmp_in,
  input wire logic temp_sd_cmp_in,
  input wire logic supply_uv_cmp_in,
  input wire logic supply_ov_cmp_in,
  input wire logic [5:0] hs_drive_out,
  input wire logic [5:0] ls_drive_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // Counts cycles that switch 0 stays driven into an overcurrent; a bound on it
  // catches a filter that never expires, without a long repetition.
  logic [8:0] oc_cnt_reg;
  logic [8:0] oc_cnt_next;
  always_comb begin
    oc_cnt_next = (hs_oc_cmp_in[0] && hs_drive_out[0]) ? oc_cnt_reg + 9'h001 : 9'h000;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_cnt_reg <= 9'h000;
    end else begin
      oc_cnt_reg <= oc_cnt_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_live_setup;
    psel_in && !penable_in && !pwrite_in && paddr_in == `HBFS_ADDR_LIVE;
  endsequence
  sequence s_tsd_held;
    temp_sd_cmp_in [*5];
  endsequence
  property p_ready;
    psel_in && penable_in |-> pready_out;
  endproperty
  property p_err_access;
    pslverr_out |-> psel_in && penable_in;
  endproperty
  property p_err_unmapped;
    // A refused write leaves the last read word in place; only a refused read must show zero.
    psel_in && penable_in && paddr_in > `HBFS_ADDR_LIVE |->
      pslverr_out && (pwrite_in || prdata_out == 32'h0);
  endproperty
  property p_live;
    s_live_setup |=> prdata_out == {18'h0, $past(ls_drive_out), 2'h0, $past(hs_drive_out)};
  endproperty
  property p_tsd_off;
    s_tsd_held |=> hs_drive_out == 6'h00 && ls_drive_out == 6'h00;
  endproperty
  property p_tsd_latch;
    s_tsd_held ##1 (!psel_in) [*4] |-> hs_drive_out == 6'h00 && ls_drive_out == 6'h00;
  endproperty
  property p_uv_off;
    supply_uv_cmp_in [*4] |=> hs_drive_out == 6'h00 && ls_drive_out == 6'h00;
  endproperty
  property p_ov_off;
    supply_ov_cmp_in [*4] |=> hs_drive_out == 6'h00 && ls_drive_out == 6'h00;
  endproperty
  property p_oc_bound;
    oc_cnt_reg < 9'h106;
  endproperty
  property p_oc_held;
    $fell(hs_drive_out[0]) && oc_cnt_reg > 9'h0C8 ##1 (!psel_in) [*6] |-> !hs_drive_out[0];
  endproperty
  property p_reset_out;
    $rose(rst_n_in) |-> hs_drive_out == 6'h00 && ls_drive_out == 6'h00;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_access: assert property (p_err_access) else $error("pslverr outside access");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  a_live: assert property (p_live) else $error("live word differs from gates");
  a_tsd_off: assert property (p_tsd_off) else $error("gates on in shutdown");
  a_tsd_latch: assert property (p_tsd_latch) else $error("shutdown not latched");
  a_uv_off: assert property (p_uv_off) else $error("gates on in undervoltage");
  a_ov_off: assert property (p_ov_off) else $error("gates on in overvoltage");
  a_oc_bound: assert property (p_oc_bound) else $error("overcurrent never cut");
  a_oc_held: assert property (p_oc_held) else $error("switch back on uncleared");
  a_reset_out: assert property (p_reset_out) else $error("gates on after reset");
endmodule // hbfs_checker
bind hbfs_top hbfs_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .hs_oc_cmp_in(hs_oc_cmp_in),
  .temp_sd_cmp_in(temp_sd_cmp_in), .supply_uv_cmp_in(supply_uv_cmp_in),
  .supply_ov_cmp_in(supply_ov_cmp_in), .hs_drive_out(hs_drive_out),
  .ls_drive_out(ls_drive_out));

//--- sim/hbfs_host.sv
// Host model: an APB master that reads and clears the supervisor status words.
`timescale 1ns/1ns
module hbfs_host (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwrite_out <= 1'b0;
    paddr_out <= 12'h000;
    pwdata_out <= 32'h0;
  end
  // One transfer; it waits an edge first so back-to-back calls never collide.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) @(posedge clk_in);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out <= ~d; // Stale data is scrambled, never left looking valid.
  endtask
endmodule // hbfs_host

//--- sim/tb_top.sv
// Self-checking bench for the half-bridge fault supervisor.
`timescale 1ns/1ns
`include "hbfs_params.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] hs_oc = 6'h00, ls_oc = 6'h00, hs_ol = 6'h00, ls_ol = 6'h00;
  logic [5:0] hs_fw = 6'h00, ls_fw = 6'h00, hs_drv, ls_drv;
  logic warn = 1'b0, thermal_shutdown_flag = 1'b0, uv = 1'b0, ov = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 clk_in = ~clk_in;
  hbfs_host host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  hbfs_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .hs_oc_cmp_in(hs_oc), .ls_oc_cmp_in(ls_oc),
    .hs_ol_cmp_in(hs_ol), .ls_ol_cmp_in(ls_ol), .temp_warn_cmp_in(warn),
    .temp_sd_cmp_in(thermal_shutdown_flag), .supply_uv_cmp_in(uv), .supply_ov_cmp_in(ov),
    .hs_fw_active_in(hs_fw), .ls_fw_active_in(ls_fw), .hs_drive_out(hs_drv),
    .ls_drive_out(ls_drv));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q, er);
    `CHK(q, e)
    `CHK(er, 1'b0)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, er);
  endtask
  // Gates are looked at on the falling edge, well clear of their update.
  task automatic drv(input logic [5:0] h, input logic [5:0] l);
    @(negedge clk_in);
    `CHK(hs_drv, h)
    `CHK(ls_drv, l)
    @(posedge clk_in);
  endtask
  task test_done;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(20000 * 40);
    n_mismatch++;
    test_done();
  end
  initial begin
    cyc(8);
    rst_n_in <= 1'b1;
    rd(`HBFS_ADDR_GLOBAL, 32'h0);
    host.xfer(1'b0, 12'h01C, 32'h0, q, er);
    `CHK(er, 1'b1)
    `CHK(q, 32'h0)
    wr(`HBFS_ADDR_ACT, 32'h0000_0103);
    cyc(3);
    rd(`HBFS_ADDR_LIVE, 32'h0000_0103);
    drv(6'h03, 6'h01);
    hs_oc <= 6'h01;
    cyc(270);
    drv(6'h02, 6'h01);
    rd(`HBFS_ADDR_OC_A, 32'h1);
    rd(`HBFS_ADDR_GLOBAL, 32'h40);
    rd(`HBFS_ADDR_ACT, 32'h0000_0103);
    hs_oc <= 6'h00;
    cyc(5);
    drv(6'h02, 6'h01);
    wr(`HBFS_ADDR_OC_A, 32'h1);
    cyc(3);
    drv(6'h03, 6'h01);
    rd(`HBFS_ADDR_OC_A, 32'h0);
    wr(`HBFS_ADDR_GLOBAL, 32'h40);
    // Low side of bridge one: the same cut and latch, reported in the second word.
    ls_oc <= 6'h01;
    cyc(270);
    drv(6'h03, 6'h00);
    rd(`HBFS_ADDR_OC_B, 32'h1);
    rd(`HBFS_ADDR_GLOBAL, 32'h40);
    ls_oc <= 6'h00;
    wr(`HBFS_ADDR_OC_B, 32'h1);
    wr(`HBFS_ADDR_GLOBAL, 32'h40);
    cyc(3);
    drv(6'h03, 6'h01);
    rd(`HBFS_ADDR_OC_B, 32'h0);
    ls_ol <= 6'h01;
    hs_ol <= 6'h02;
    hs_fw <= 6'h02;
    cyc(5100);
    rd(`HBFS_ADDR_OL_B, 32'h1);
    rd(`HBFS_ADDR_OL_A, 32'h0);
    rd(`HBFS_ADDR_GLOBAL, 32'h40);
    drv(6'h03, 6'h01);
    ls_ol <= 6'h00;
    hs_ol <= 6'h00;
    // The filter keeps reporting until the synchronised level has dropped; a clear issued
    // sooner is overridden by the still-standing expiry.
    cyc(4);
    wr(`HBFS_ADDR_OL_B, 32'h1);
    wr(`HBFS_ADDR_GLOBAL, 32'h40);
    rd(`HBFS_ADDR_OL_B, 32'h0);
    warn <= 1'b1;
    cyc(6);
    drv(6'h03, 6'h01);
    warn <= 1'b0;
    cyc(3);
    rd(`HBFS_ADDR_GLOBAL, 32'h02);
    wr(`HBFS_ADDR_GLOBAL, 32'h02);
    rd(`HBFS_ADDR_GLOBAL, 32'h0);
    thermal_shutdown_flag <= 1'b1;
    cyc(6);
    drv(6'h00, 6'h00);
    thermal_shutdown_flag <= 1'b0;
    cyc(5);
    drv(6'h00, 6'h00);
    rd(`HBFS_ADDR_GLOBAL, 32'h04);
    rd(`HBFS_ADDR_ACT, 32'h0000_0103);
    wr(`HBFS_ADDR_GLOBAL, 32'h04);
    cyc(3);
    drv(6'h03, 6'h01);
    for (int i = 0; i < 2; i++) begin
      {uv, ov} <= (i == 0) ? 2'b10 : 2'b01;
      cyc(6);
      drv(6'h00, 6'h00);
      {uv, ov} <= 2'b00;
      cyc(5);
      drv(6'h03, 6'h01);
      rd(`HBFS_ADDR_GLOBAL, (i == 0) ? 32'h20 : 32'h10);
      wr(`HBFS_ADDR_GLOBAL, 32'h30);
    end
    rd(`HBFS_ADDR_GLOBAL, 32'h0);
    test_done();
  end
endmodule // tb_top
